// ==== dv/qd_decoder_test.sv ====
// self-checking bench for the decoder registers and interrupt
`timescale 1ns/10ps
`default_nettype none
module qd_decoder_test;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [31:0] rnd;
	logic [31:0] qe;
	logic [31:0] ie;
	logic pready;
	logic pslverr;
	logic irq;
	logic [2:0] quad_a;
	logic [2:0] quad_b;
	logic [2:0] index_in;
	logic [2:0] st_up = 3'h0;
	logic [2:0] st_dn = 3'h0;
	logic [2:0] ix = 3'h0;
	logic [32:0] exp_q [$];
	logic irq_q [$];
	logic irq_look = 1'b0;
	int fails = 0;
	int compares = 0;
	int cyc = 0;
	always #25 ref_clk = ~ref_clk;
	qd_decoder #(.NUM_AXES(3)) dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .quad_a(quad_a),
		.quad_b(quad_b), .index_in(index_in), .irq(irq));
	qd_enc_model enc (.ref_clk(ref_clk), .sys_rst(sys_rst), .step_up(st_up),
		.step_dn(st_dn), .index_drv(ix), .quad_a(quad_a), .quad_b(quad_b),
		.index_in(index_in));
	task finish_test;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task chk(input logic [32:0] seen, input logic [32:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// read results are judged where they appear, against the oldest note
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			finish_test();
		end
		if (psel && penable && pready && !pwrite) begin
			chk({pslverr, prdata}, exp_q.pop_front());
		end
		if (irq_look) begin
			chk({32'h0, irq}, {32'h0, irq_q.pop_front()});
		end
	end
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task rd(input logic [11:0] a, input logic [31:0] e, input logic err = 1'b0);
		exp_q.push_back({err, e});
		apb(1'b0, a, 32'h0);
	endtask
	// irq is judged one edge later, from registers settled by the last transfer
	task irq_is(input logic e);
		irq_q.push_back(e);
		irq_look <= 1'b1;
		@(posedge ref_clk);
		irq_look <= 1'b0;
	endtask
	task step(input logic [2:0] u, input logic [2:0] d);
		st_up <= u;
		st_dn <= d;
		@(posedge ref_clk);
		st_up <= 3'h0;
		st_dn <= 3'h0;
		repeat (3) @(posedge ref_clk);
	endtask
	task pulse(input int n);
		ix <= 3'h7;
		repeat (n) @(posedge ref_clk);
		ix <= 3'h0;
		repeat (3) @(posedge ref_clk);
	endtask
	task do_reset;
		sys_rst <= 1'b1;
		repeat (16) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(posedge ref_clk);
	endtask
	function automatic logic [11:0] ax(input int i, input logic [11:0] o);
		return qd_pkg::AXIS_BASE + qd_pkg::AXIS_STRIDE * 12'(i) + o;
	endfunction
	initial begin
		rnd = $urandom(43);
		do_reset();
		for (int a = 0; a < 16; a += 4) begin
			rd(12'(a), 32'h0);
		end
		wr(12'h004, 32'hffff_ffff);
		rd(12'h004, 32'h3f55_5555);
		wr(12'h004, 32'h0);
		rnd = $urandom;
		wr(12'h00c, rnd);
		rd(12'h00c, 32'h0);
		rd(12'h008, 32'h0);
		rd(12'h100, 32'h0, 1'b1);
		for (int i = 0; i < 3; i++) begin
			wr(ax(i, qd_pkg::MODE_OFS), 32'h0000_0003);
		end
		// channels off: a step forward and back must leave no trace
		step(3'h7, 3'h0);
		step(3'h0, 3'h7);
		rd(12'h00c, 32'h0);
		wr(12'h000, 32'hffff_ffff);
		rd(12'h000, 32'h0000_0111);
		step(3'h7, 3'h0);
		rd(12'h00c, 32'h0001_0101);
		irq_is(1'b0);
		wr(12'h004, 32'h0000_0001);
		irq_is(1'b1);
		wr(12'h008, 32'h0000_0001);
		rd(12'h00c, 32'h0001_0100);
		irq_is(1'b0);
		wr(12'h008, 32'h3f11_1111);
		step(3'h0, 3'h7);
		step(3'h0, 3'h7);
		rd(12'h00c, 32'h2a01_0101);
		wr(12'h004, 32'h0200_0000);
		irq_is(1'b1);
		wr(12'h008, 32'h3f00_0000);
		rd(12'h00c, 32'h0001_0101);
		irq_is(1'b0);
		wr(12'h008, 32'h3f11_1111);
		wr(12'h004, 32'h0004_0404);
		for (int i = 0; i < 3; i++) begin
			wr(ax(i, qd_pkg::QHIT_OFS), 32'h1);
		end
		step(3'h7, 3'h0);
		rd(12'h00c, 32'h1500_0000);
		step(3'h7, 3'h0);
		rd(12'h00c, 32'h1501_0101);
		wr(ax(1, qd_pkg::QHIT_OFS), rnd);
		rd(ax(1, qd_pkg::QHIT_OFS), rnd);
		wr(ax(1, qd_pkg::IHIT_OFS), ~rnd);
		rd(ax(1, qd_pkg::IHIT_OFS), ~rnd);
		wr(12'h008, 32'h3f11_1111);
		for (int i = 0; i < 3; i++) begin
			wr(ax(i, qd_pkg::MODE_OFS), 32'h0001_0003);
		end
		wr(12'h004, 32'h0000_0010);
		pulse(1);
		rd(12'h00c, 32'h0010_1010);
		irq_is(1'b1);
		wr(12'h008, 32'h0010_1010);
		rd(12'h00c, 32'h0);
		wr(ax(0, qd_pkg::IHIT_OFS), 32'h2);
		wr(12'h004, 32'h0000_0050);
		pulse(1);
		rd(12'h00c, 32'h0010_1010);
		wr(12'h008, 32'h3f11_1111);
		pulse(1);
		rd(12'h00c, 32'h0010_1000);
		irq_is(1'b0);
		// second reset, then count resolution and index counting on x alone
		do_reset();
		rd(12'h004, 32'h0);
		wr(12'h000, 32'h0000_0001);
		qe = 32'h0;
		ie = 32'h0;
		for (int m = 1; m < 4; m++) begin
			wr(ax(0, qd_pkg::MODE_OFS), 32'(m));
			repeat (4) step(3'h1, 3'h0);
			qe = qe + ((m == 3) ? 32'h4 : 32'(m));
			rd(ax(0, qd_pkg::QCNT_OFS), qe);
		end
		for (int m = 0; m < 4; m++) begin
			wr(ax(0, qd_pkg::MODE_OFS), 32'(m) << 16);
			pulse(3);
			ie = ie + ((m == 0) ? 32'h3 : (m == 3) ? 32'h2 : 32'h1);
			rd(ax(0, qd_pkg::ICNT_OFS), ie);
		end
		repeat (2) @(posedge ref_clk);
		finish_test();
	end
endmodule
`default_nettype wire

// ==== dv/qd_enc_model.sv ====
// encoder model: gray-coded phases and index line for each axis
`timescale 1ns/10ps
`default_nettype none
module qd_enc_model (
	input wire logic ref_clk, // system clock
	input wire logic sys_rst, // synchronous reset, high
	input wire logic [2:0] step_up, // one step forward per axis
	input wire logic [2:0] step_dn, // one step backward per axis
	input wire logic [2:0] index_drv, // wanted index level per axis
	output logic [2:0] quad_a, // phase a per axis
	output logic [2:0] quad_b, // phase b per axis
	output logic [2:0] index_in // index per axis
);
	logic [1:0] ph_ff [3];
	// phase order 00,10,11,01 moves forward, so a is the xor of the phase bits
	always_ff @(posedge ref_clk) begin
		for (int i = 0; i < 3; i++) begin
			if (sys_rst) begin
				ph_ff[i] <= 2'h0;
			end else begin
				ph_ff[i] <= ph_ff[i] + {1'b0, step_up[i]} - {1'b0, step_dn[i]};
			end
			quad_a[i] <= ph_ff[i][0] ^ ph_ff[i][1];
			quad_b[i] <= ph_ff[i][1];
		end
		index_in <= sys_rst ? 3'h0 : index_drv;
	end
endmodule
`default_nettype wire

// ==== verilog/qd_decoder.sv ====
// three-axis quadrature decoder with apb registers and interrupt status
`timescale 1ns/10ps
`default_nettype none
module qd_decoder #(
	parameter int NUM_AXES = 3
) (
	input wire logic ref_clk, // 20 MHz system clock
	input wire logic sys_rst, // synchronous reset, high
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction
	input wire logic [11:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // unmapped address
	input wire logic [NUM_AXES-1:0] quad_a, // encoder phase a per axis
	input wire logic [NUM_AXES-1:0] quad_b, // encoder phase b per axis
	input wire logic [NUM_AXES-1:0] index_in, // encoder index per axis
	output logic irq // level interrupt
);
	logic [31:0] chan_ff, nxt_chan;
	logic [31:0] ien_ff, nxt_ien;
	logic [31:0] stat_ff, nxt_stat;
	logic [31:0] mode_ff [NUM_AXES];
	logic [31:0] nxt_mode [NUM_AXES];
	logic [31:0] qhit_ff [NUM_AXES];
	logic [31:0] nxt_qhit [NUM_AXES];
	logic [31:0] ihit_ff [NUM_AXES];
	logic [31:0] nxt_ihit [NUM_AXES];
	logic [31:0] qcnt_ff [NUM_AXES];
	logic [31:0] nxt_qcnt [NUM_AXES];
	logic [31:0] icnt_ff [NUM_AXES];
	logic [31:0] nxt_icnt [NUM_AXES];
	logic [NUM_AXES-1:0] a_ff, b_ff, idx_ff;
	logic [NUM_AXES-1:0] qstep, qup, istep;
	logic [NUM_AXES-1:0] ev_q, ev_i, ev_up, ev_dn;
	logic [31:0] prdata_ff, nxt_prdata;
	logic [31:0] rd_val, set_vec, clr_vec;
	logic hit, wr_acc, rd_setup;

	assign wr_acc = psel & penable & pwrite;
	assign rd_setup = psel & ~penable & ~pwrite;
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~hit;
	assign prdata = prdata_ff;
	// enable mode bits never match a status bit, so the and is safe
	assign irq = |(stat_ff & ien_ff); // RQ17

	// address decode and read value
	always_comb begin
		logic [11:0] ab;
		ab = 12'h000;
		hit = 1'b0;
		rd_val = 32'h0000_0000;
		case (paddr)
			qd_pkg::CHAN_EN_OFS: begin
				hit = 1'b1;
				rd_val = chan_ff;
			end
			qd_pkg::IRQ_EN_OFS: begin
				hit = 1'b1;
				rd_val = ien_ff;
			end
			qd_pkg::IRQ_CLR_OFS: begin
				hit = 1'b1;
			end
			qd_pkg::IRQ_STAT_OFS: begin
				hit = 1'b1;
				rd_val = stat_ff; // RQ10 RQ11 RQ12
			end
			default: begin
				hit = 1'b0;
			end
		endcase
		for (int i = 0; i < NUM_AXES; i++) begin
			ab = qd_pkg::AXIS_BASE + 12'(i) * qd_pkg::AXIS_STRIDE;
			if (paddr == ab + qd_pkg::MODE_OFS) begin
				hit = 1'b1;
				rd_val = mode_ff[i];
			end
			if (paddr == ab + qd_pkg::QHIT_OFS) begin
				hit = 1'b1;
				rd_val = qhit_ff[i];
			end
			if (paddr == ab + qd_pkg::IHIT_OFS) begin
				hit = 1'b1;
				rd_val = ihit_ff[i];
			end
			if (paddr == ab + qd_pkg::QCNT_OFS) begin
				hit = 1'b1;
				rd_val = qcnt_ff[i];
			end
			if (paddr == ab + qd_pkg::ICNT_OFS) begin
				hit = 1'b1;
				rd_val = icnt_ff[i];
			end
		end
	end

	// software-written registers; counts and status ignore writes
	always_comb begin
		logic [11:0] ab;
		ab = 12'h000;
		nxt_chan = chan_ff;
		nxt_ien = ien_ff;
		nxt_prdata = rd_setup ? rd_val : prdata_ff;
		if (wr_acc && paddr == qd_pkg::CHAN_EN_OFS)
			nxt_chan = pwdata & qd_pkg::CHAN_EN_MASK; // RQ18
		if (wr_acc && paddr == qd_pkg::IRQ_EN_OFS)
			nxt_ien = pwdata & qd_pkg::IRQ_EN_MASK; // RQ1 RQ2 RQ3 RQ4
		for (int i = 0; i < NUM_AXES; i++) begin
			ab = qd_pkg::AXIS_BASE + 12'(i) * qd_pkg::AXIS_STRIDE;
			nxt_mode[i] = mode_ff[i];
			nxt_qhit[i] = qhit_ff[i];
			nxt_ihit[i] = ihit_ff[i];
			if (wr_acc && paddr == ab + qd_pkg::MODE_OFS)
				nxt_mode[i] = pwdata & qd_pkg::MODE_MASK;
			if (wr_acc && paddr == ab + qd_pkg::QHIT_OFS)
				nxt_qhit[i] = pwdata; // RQ13
			if (wr_acc && paddr == ab + qd_pkg::IHIT_OFS)
				nxt_ihit[i] = pwdata; // RQ14
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			chan_ff <= qd_pkg::REG_RST;
			ien_ff <= qd_pkg::REG_RST;
			prdata_ff <= qd_pkg::REG_RST;
			for (int i = 0; i < NUM_AXES; i++) begin
				mode_ff[i] <= qd_pkg::REG_RST;
				qhit_ff[i] <= qd_pkg::REG_RST;
				ihit_ff[i] <= qd_pkg::REG_RST;
			end
		end else begin
			chan_ff <= nxt_chan;
			ien_ff <= nxt_ien;
			prdata_ff <= nxt_prdata;
			for (int i = 0; i < NUM_AXES; i++) begin
				mode_ff[i] <= nxt_mode[i];
				qhit_ff[i] <= nxt_qhit[i];
				ihit_ff[i] <= nxt_ihit[i];
			end
		end
	end

	// count engine; inputs are sampled every cycle so enabling never fakes a step
	always_comb begin
		logic da, db, ri, fi, qm, im;
		da = 1'b0;
		db = 1'b0;
		ri = 1'b0;
		fi = 1'b0;
		qm = 1'b0;
		im = 1'b0;
		for (int i = 0; i < NUM_AXES; i++) begin
			da = quad_a[i] ^ a_ff[i];
			db = quad_b[i] ^ b_ff[i];
			ri = index_in[i] & ~idx_ff[i];
			fi = ~index_in[i] & idx_ff[i];
			qup[i] = quad_a[i] ^ b_ff[i];
			case (mode_ff[i][qd_pkg::QCM_LSB +: 2]) // RQ15
				qd_pkg::QM_X1: qstep[i] = da & quad_a[i] & ~db;
				qd_pkg::QM_X2: qstep[i] = da & ~db;
				qd_pkg::QM_X4: qstep[i] = da ^ db;
				default: qstep[i] = 1'b0;
			endcase
			case (mode_ff[i][qd_pkg::ICM_LSB +: 2]) // RQ16
				qd_pkg::IM_LEVEL: istep[i] = index_in[i];
				qd_pkg::IM_RISE: istep[i] = ri;
				qd_pkg::IM_FALL: istep[i] = fi;
				qd_pkg::IM_BOTH: istep[i] = ri | fi;
				default: istep[i] = 1'b0;
			endcase
			qstep[i] = qstep[i] & chan_ff[i * qd_pkg::CHAN_EN_STRIDE]; // RQ18
			istep[i] = istep[i] & chan_ff[i * qd_pkg::CHAN_EN_STRIDE]; // RQ18
			nxt_qcnt[i] = qcnt_ff[i];
			if (qstep[i])
				nxt_qcnt[i] = qup[i] ? qcnt_ff[i] + 32'h1 : qcnt_ff[i] - 32'h1;
			nxt_icnt[i] = istep[i] ? icnt_ff[i] + 32'h1 : icnt_ff[i];
			ev_up[i] = qstep[i] & ~qup[i] & (qcnt_ff[i] == 32'h0000_0000);
			ev_dn[i] = qstep[i] & qup[i] & (qcnt_ff[i] == 32'hffff_ffff);
			qm = ien_ff[i * qd_pkg::FIELD_STRIDE + qd_pkg::QMODE_POS];
			im = ien_ff[i * qd_pkg::FIELD_STRIDE + qd_pkg::IMODE_POS];
			ev_q[i] = qstep[i] & (~qm | (nxt_qcnt[i] == qhit_ff[i])); // RQ6
			ev_i[i] = istep[i] & (~im | (nxt_icnt[i] == ihit_ff[i])); // RQ5
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			a_ff <= '0;
			b_ff <= '0;
			idx_ff <= '0;
			for (int i = 0; i < NUM_AXES; i++) begin
				qcnt_ff[i] <= qd_pkg::REG_RST;
				icnt_ff[i] <= qd_pkg::REG_RST;
			end
		end else begin
			a_ff <= quad_a;
			b_ff <= quad_b;
			idx_ff <= index_in;
			for (int i = 0; i < NUM_AXES; i++) begin
				qcnt_ff[i] <= nxt_qcnt[i];
				icnt_ff[i] <= nxt_icnt[i];
			end
		end
	end

	// sticky status; a set in the clearing cycle wins
	always_comb begin
		set_vec = 32'h0000_0000;
		for (int i = 0; i < NUM_AXES; i++) begin
			set_vec[i * qd_pkg::FIELD_STRIDE + qd_pkg::QIRQ_POS] = ev_q[i];
			set_vec[i * qd_pkg::FIELD_STRIDE + qd_pkg::IIRQ_POS] = ev_i[i];
			set_vec[qd_pkg::DN_WRAP_POS + 2 * i] = ev_dn[i];
			set_vec[qd_pkg::UP_WRAP_POS + 2 * i] = ev_up[i];
		end
		clr_vec = 32'h0000_0000;
		if (wr_acc && paddr == qd_pkg::IRQ_CLR_OFS)
			clr_vec = pwdata & qd_pkg::STAT_MASK; // RQ7 RQ8 RQ9
		nxt_stat = (stat_ff & ~clr_vec) | set_vec; // RQ17
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			stat_ff <= qd_pkg::REG_RST; // RQ12
		else
			stat_ff <= nxt_stat;
	end

	property p_hold_off;
		@(posedge ref_clk) disable iff (sys_rst)
		!chan_ff[0] |=> $stable(qcnt_ff[0]) && $stable(icnt_ff[0]);
	endproperty
	a_hold_off: assert property (p_hold_off) else $error("disabled axis counted"); // RQ18

	property p_sticky;
		@(posedge ref_clk) disable iff (sys_rst)
		stat_ff[0] && !(wr_acc && paddr == qd_pkg::IRQ_CLR_OFS && pwdata[0])
		|=> stat_ff[0];
	endproperty
	a_sticky: assert property (p_sticky) else $error("status lost without clear"); // RQ17

	property p_irq_off;
		@(posedge ref_clk) disable iff (sys_rst)
		ien_ff == 32'h0 |-> !irq;
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("irq with nothing enabled"); // RQ3

	property p_irq_on;
		@(posedge ref_clk) disable iff (sys_rst)
		stat_ff[0] && ien_ff[0] |-> irq;
	endproperty
	a_irq_on: assert property (p_irq_on) else $error("enabled status gave no irq"); // RQ4

	property p_clr_up;
		@(posedge ref_clk) disable iff (sys_rst)
		wr_acc && paddr == qd_pkg::IRQ_CLR_OFS && pwdata[29] && !ev_up[2]
		|=> !stat_ff[29];
	endproperty
	a_clr_up: assert property (p_clr_up) else $error("up wrap not cleared"); // RQ7

	property p_clr_idx;
		@(posedge ref_clk) disable iff (sys_rst)
		wr_acc && paddr == qd_pkg::IRQ_CLR_OFS && pwdata[4] && !ev_i[0]
		|=> !stat_ff[4];
	endproperty
	a_clr_idx: assert property (p_clr_idx) else $error("index status not cleared"); // RQ8

	property p_stat_wr;
		@(posedge ref_clk) disable iff (sys_rst)
		wr_acc && paddr == qd_pkg::IRQ_STAT_OFS && stat_ff[4] |=> stat_ff[4];
	endproperty
	a_stat_wr: assert property (p_stat_wr) else $error("status write had effect"); // RQ11

	property p_up_wrap;
		@(posedge ref_clk) disable iff (sys_rst)
		qstep[0] && !qup[0] && qcnt_ff[0] == 32'h0 |=> stat_ff[25] && &qcnt_ff[0];
	endproperty
	a_up_wrap: assert property (p_up_wrap) else $error("up wrap missed"); // RQ1

	property p_match;
		@(posedge ref_clk) disable iff (sys_rst)
		!stat_ff[0] && ien_ff[2] && !(qstep[0] && nxt_qcnt[0] == qhit_ff[0])
		|=> !stat_ff[0];
	endproperty
	a_match: assert property (p_match) else $error("match mode fired early"); // RQ6

	property p_dn_wrap;
		@(posedge ref_clk) disable iff (sys_rst)
		qstep[0] && qup[0] && &qcnt_ff[0] |=> stat_ff[24] && qcnt_ff[0] == 32'h0;
	endproperty
	a_dn_wrap: assert property (p_dn_wrap) else $error("down wrap missed"); // RQ2

	property p_idx_any;
		@(posedge ref_clk) disable iff (sys_rst)
		istep[0] && !ien_ff[6] |=> stat_ff[4];
	endproperty
	a_idx_any: assert property (p_idx_any) else $error("index change not flagged"); // RQ5

	property p_clr_q;
		@(posedge ref_clk) disable iff (sys_rst)
		wr_acc && paddr == qd_pkg::IRQ_CLR_OFS && pwdata[0] && !ev_q[0]
		|=> !stat_ff[0];
	endproperty
	a_clr_q: assert property (p_clr_q) else $error("count status not cleared"); // RQ9
endmodule
`default_nettype wire

// ==== verilog/qd_pkg.sv ====
// register map, field positions and codes of the quadrature decoder block
// Behaviour
// RQ1 - per-axis enable for up-wrap interrupt, bits 29/27/25, reset zero
// RQ2 - per-axis enable for down-wrap interrupt, bits 28/26/24, reset zero
// RQ3 - index-count interrupt enable at bits 20/12/4 gates that interrupt
// RQ4 - quadrature-count interrupt enable at bits 16/8/0 gates that interrupt
// RQ5 - index mode bit 22/14/6: zero any change, one count equals compare
// RQ6 - quadrature mode bit 18/10/2: zero any change, one count equals compare
// RQ7 - clear register 0x08 bits 29..24 clear the wrap status bits
// RQ8 - clear bits 20/12/4 clear the pending index-count status
// RQ9 - clear bits 16/8/0 clear the pending quadrature-count status
// RQ10 - status register 0x0C shows wrap status at bits 29..24
// RQ11 - status shows index-count pending at 20/12/4; writes ignored
// RQ12 - status shows quadrature pending at 16/8/0; read-only, reset zero
// RQ13 - each axis holds a writable 32-bit quadrature compare value
// RQ14 - each axis holds a writable 32-bit index compare value
// RQ15 - quadrature mode field: 01 single, 10 double, 11 highest multiplier
// RQ16 - index mode field: 00 level, 01 rising, 10 falling, 11 both edges
// RQ17 - status sets on trigger, stays until cleared, irq only when enabled
// RQ18 - axis counts and raises events only while its channel enable is set
package qd_pkg;
	localparam int ADDR_W = 12;
	localparam logic [11:0] CHAN_EN_OFS = 12'h000;
	localparam logic [11:0] IRQ_EN_OFS = 12'h004;
	localparam logic [11:0] IRQ_CLR_OFS = 12'h008;
	localparam logic [11:0] IRQ_STAT_OFS = 12'h00c;
	localparam logic [11:0] AXIS_BASE = 12'h010;
	localparam logic [11:0] AXIS_STRIDE = 12'h014;
	localparam logic [11:0] MODE_OFS = 12'h000;
	localparam logic [11:0] QHIT_OFS = 12'h004;
	localparam logic [11:0] IHIT_OFS = 12'h008;
	localparam logic [11:0] QCNT_OFS = 12'h00c;
	localparam logic [11:0] ICNT_OFS = 12'h010;
	localparam int CHAN_EN_STRIDE = 4;
	localparam int FIELD_STRIDE = 8;
	localparam int QIRQ_POS = 0;
	localparam int QMODE_POS = 2;
	localparam int IIRQ_POS = 4;
	localparam int IMODE_POS = 6;
	localparam int DN_WRAP_POS = 24;
	localparam int UP_WRAP_POS = 25;
	localparam int QCM_LSB = 0;
	localparam int ICM_LSB = 16;
	localparam logic [31:0] CHAN_EN_MASK = 32'h0000_0111;
	localparam logic [31:0] IRQ_EN_MASK = 32'h3f55_5555;
	localparam logic [31:0] STAT_MASK = 32'h3f11_1111;
	localparam logic [31:0] MODE_MASK = 32'h0003_0003;
	localparam logic [31:0] REG_RST = 32'h0000_0000;
	localparam logic [1:0] QM_X1 = 2'h1;
	localparam logic [1:0] QM_X2 = 2'h2;
	localparam logic [1:0] QM_X4 = 2'h3;
	localparam logic [1:0] IM_LEVEL = 2'h0;
	localparam logic [1:0] IM_RISE = 2'h1;
	localparam logic [1:0] IM_FALL = 2'h2;
	localparam logic [1:0] IM_BOTH = 2'h3;
endpackage
